// [dv/tb_top.sv]
// Self-checking bench for the bus timing step sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [3:0] pstrb = 4'h1;
	logic pready, pslverr, sclk_out, sclk_oe_n, sclk_drv, e;
	wire sclk_line = sclk_oe_n ? sclk_drv : sclk_out;
	tss_pkg::tss_step_t step_index;
	int err_total = 0, comparisons = 0, cyc = 0, x;
	tss_top dut_u (.ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclk_in(sclk_line), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
		.step_index(step_index));
	tss_node_model node_u (.rst(rst), .sclk_pin(sclk_line), .sclk_drv(sclk_drv));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// APB transfer: request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Only the hang guard ends a wait that never sees pready
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic final_report();
		$display("comparisons=%0d mismatches=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Hang guard, well above the expected run length
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		apb(1'b0, 8'h14, 32'h0);
		`CHK({e, r}, 33'h0)
		apb(1'b1, 8'h14, 32'hffffffff);
		apb(1'b0, 8'h14, 32'h0);
		`CHK({e, r, step_index}, 39'h0)
		apb(1'b0, 8'h40, 32'h0);
		`CHK({e, r}, {1'b1, 32'h0})
		$display("test reset_and_access done");
		// Sweep past the wrap; every step checked against node and decode
		for (int s = 1; s <= 40; s++) begin
			node_u.pulse(1);
			repeat (4) @(posedge ref_clk);
			x = s % 38;
			`CHK(step_index, 6'(x))
			`CHK(step_index, node_u.step)
			apb(1'b0, 8'h14, 32'h0);
			`CHK(r, (x >= 31) ? (32'h1 << (x - 31)) : 32'h0)
		end
		$display("test step_sweep done");
		apb(1'b1, 8'h18, 32'h1);
		apb(1'b0, 8'h18, 32'h0);
		`CHK({r[0], sclk_oe_n}, 2'b10)
		repeat (100) @(posedge ref_clk);
		`CHK(step_index, node_u.step)
		apb(1'b1, 8'h18, 32'h0);
		repeat (8) @(posedge ref_clk);
		`CHK(sclk_oe_n, 1'b1)
		`CHK(step_index, node_u.step)
		$display("test local_clock done");
		rst <= 1'b1;
		@(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		`CHK({step_index, node_u.step}, 12'h0)
		$display("test mid_reset done");
		final_report();
	end
endmodule // tb_top

// [dv/tss_node_model.sv]
// Far-side bus node: makes the serial clock in frames and tracks the shared step
`timescale 1ns/100ps
module tss_node_model (
	input wire logic rst, // System reset
	input wire logic sclk_pin, // Resolved serial clock line
	output logic sclk_drv // Serial clock value this node drives
);
	tss_pkg::tss_step_t step = 6'h00; // Reset at time 0 raises no edge on rst
	initial sclk_drv = 1'b0;
	// Counts every rising edge of the shared line, so it must match the design
	always @(posedge sclk_pin or posedge rst) begin
		if (rst)
			step <= 6'h00;
		else
			step <= (step == 6'h25) ? 6'h00 : step + 6'h01;
	end
	// Clock stands low between frames, 80 ns period inside them
	task automatic pulse(input int n);
		repeat (n) begin
			#40 sclk_drv <= 1'b1;
			#40 sclk_drv <= 1'b0;
		end
	endtask
endmodule // tss_node_model

// [hw/tss_defs.svh]
// Offsets, reset values, field positions and timing counts of the bus timing sequencer
`ifndef TSS_DEFS_SVH
`define TSS_DEFS_SVH
`define TSS_STEP_OFF 8'h14
`define TSS_CTRL_OFF 8'h18
`define TSS_STEP_RST 8'h00
`define TSS_CTRL_RST 8'h00
`define TSS_CTRL_LOCAL_BIT 0
`define TSS_STEP_MSB_BIT 7
`define TSS_FIRST_STEP 6'h00
`define TSS_LAST_STEP 6'h25
`define TSS_VIEW_BASE 31
`define TSS_CLK_NS 10
`define TSS_SCLK_HALF_NS 40
`define TSS_SCLK_HALF_CYC ((`TSS_SCLK_HALF_NS + `TSS_CLK_NS - 1) / `TSS_CLK_NS)
`define TSS_ECHO_BLANK 2'h3
`endif

// [hw/tss_pkg.sv]
// Types shared by the bus timing sequencer
package tss_pkg;
	typedef logic [5:0] tss_step_t;
	typedef logic [37:0] tss_onehot_t;
	typedef logic [7:0] tss_view_t;
endpackage

// [hw/tss_top.sv]
// Bus timing step sequencer with APB register access
`timescale 1ns/100ps
`include "tss_defs.svh"

// Functional notes
// - The step register is read only, and bus writes to it never alter the step.
// - Each rising edge of the serial clock moves the step up by one from 0 to 37 and from 37 back to 0.
// - The step is decoded one-hot so exactly one decoded output is active, and the register shows those of steps 31 to 37.
// - Every node holds the same step at once because the step moves only on shared serial clock edges.
// - Reset puts the step counter at step 0.
// - A read may be stale when the serial clock is foreign to the processor clock; no guarantee then.
// - When the serial clock is made on this chip the step register is always in step with the bus.
// - The link is a token-passing network of chips sharing a serial clock line, data line and a chain.
module tss_top #(
	parameter int STEP_COUNT = 38, // Steps in one bus cycle
	parameter int SCLK_HALF_CYC = `TSS_SCLK_HALF_CYC // Half period of locally made serial clock
) (
	input wire logic ref_clk, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic [7:0] paddr, // APB byte address
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction, high for write
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB transfer done
	output logic pslverr, // APB error, unmapped address
	input wire logic sclk_in, // Serial clock pin level
	output logic sclk_out, // Serial clock drive value
	output logic sclk_oe_n, // Serial clock drive enable, low while driving
	output tss_pkg::tss_step_t step_index // Current step number
);

	// One-hot decode of a step number
	function automatic tss_pkg::tss_onehot_t step_decode(input tss_pkg::tss_step_t s);
		tss_pkg::tss_onehot_t v;
		v = '0;
		v[s] = 1'b1;
		return v;
	endfunction

	// Register view of the decoded outputs; the top bit is never set
	function automatic tss_pkg::tss_view_t step_view(input tss_pkg::tss_onehot_t oh);
		tss_pkg::tss_view_t v;
		v = {1'b0, oh[`TSS_VIEW_BASE +: 7]};
		return v;
	endfunction

	logic sclk_meta;
	logic sclk_sync;
	logic sclk_prev;
	logic pin_rise;
	logic local_en;
	logic [7:0] div_cnt;
	logic div_wrap;
	logic gen_rise;
	logic step_rise;
	logic [1:0] echo_blank;
	tss_pkg::tss_step_t step;
	tss_pkg::tss_step_t next_step;
	tss_pkg::tss_onehot_t step_oh;
	logic setup_phase;
	logic hit_step;
	logic hit_ctrl;

	// Two-stage synchroniser on the pin; only the second stage is looked at
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sclk_meta <= 1'b0;
			sclk_sync <= 1'b0;
		end else begin
			sclk_meta <= sclk_in;
			sclk_sync <= sclk_meta;
		end
	end

	// Edge finder on the synchronised pin level
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sclk_prev <= 1'b0;
		end else begin
			sclk_prev <= sclk_sync;
		end
	end

	// A foreign clock is seen two to three cycles late, so a host read can lag the bus
	assign pin_rise = sclk_sync & ~sclk_prev;

	// Local serial clock divider, only running when this chip makes the clock
	assign div_wrap = (div_cnt == 8'(SCLK_HALF_CYC - 1));
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_cnt <= 8'h00;
			sclk_out <= 1'b0;
		end else if (!local_en) begin
			div_cnt <= 8'h00;
			sclk_out <= 1'b0;
		end else if (div_wrap) begin
			div_cnt <= 8'h00;
			sclk_out <= ~sclk_out;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	// Rising edge of the locally made clock is known in the same cycle it is driven
	assign gen_rise = local_en & div_wrap & ~sclk_out;

	// Pin is driven only while this chip owns the serial clock
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sclk_oe_n <= 1'b1;
		end else begin
			sclk_oe_n <= ~local_en;
		end
	end

	// Blanking after local mode ends: our own last edge is still in the synchroniser
	// and would otherwise be counted a second time as a pin edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			echo_blank <= 2'h0;
		end else if (local_en) begin
			echo_blank <= `TSS_ECHO_BLANK;
		end else if (echo_blank != 2'h0) begin
			echo_blank <= echo_blank - 2'h1;
		end
	end

	// Local mode follows its own edge, not the delayed pin echo, so steps stay aligned
	assign step_rise = local_en ? gen_rise : (pin_rise & (echo_blank == 2'h0));

	// Next step with wrap after the last one
	always_comb begin
		next_step = step;
		if (step_rise) begin
			if (step == `TSS_LAST_STEP) begin
				next_step = `TSS_FIRST_STEP;
			end else begin
				next_step = step + 6'h01;
			end
		end
	end

	// Step counter and its one-hot decode kept side by side
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			step <= `TSS_FIRST_STEP;
			step_oh <= tss_pkg::tss_onehot_t'(1);
		end else begin
			step <= next_step;
			step_oh <= step_decode(next_step);
		end
	end

	// Step number for logic beside this block
	assign step_index = step;

	// APB decode
	assign setup_phase = psel & ~penable & ~pready;
	assign hit_step = (paddr == `TSS_STEP_OFF);
	assign hit_ctrl = (paddr == `TSS_CTRL_OFF);

	// Control register: the only software-steered bit selects local clock generation
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			local_en <= 1'(`TSS_CTRL_RST);
		end else if (psel && penable && pready && pwrite && hit_ctrl && pstrb[0] && !pslverr) begin
			local_en <= pwdata[`TSS_CTRL_LOCAL_BIT];
		end
	end

	// No wait state: answer is prepared in setup and shown in the first access cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup_phase;
			pslverr <= setup_phase & ~hit_step & ~hit_ctrl;
			if (setup_phase && !pwrite && hit_step) begin
				prdata <= {24'h000000, step_view(step_oh)};
			end else if (setup_phase && !pwrite && hit_ctrl) begin
				prdata <= {31'h00000000, local_en};
			end else if (setup_phase) begin
				prdata <= 32'h00000000;
			end
		end
	end

	// Checks
	step_range_a: assert property (@(posedge ref_clk) disable iff (rst)
		int'(step) < STEP_COUNT) else $error("step out of range");

	step_wrap_a: assert property (@(posedge ref_clk) disable iff (rst)
		(step_rise && step == `TSS_LAST_STEP) |=> (step == `TSS_FIRST_STEP)) else $error("step did not wrap");

	step_incr_a: assert property (@(posedge ref_clk) disable iff (rst)
		(step_rise && step != `TSS_LAST_STEP) |=> (step == $past(step) + 6'h01)) else $error("step did not advance");

	step_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!step_rise |=> $stable(step)) else $error("step moved without an edge");

	onehot_match_a: assert property (@(posedge ref_clk) disable iff (rst)
		$onehot(step_oh) && step_oh == step_decode(step)) else $error("decode not one-hot");

	read_view_a: assert property (@(posedge ref_clk) disable iff (rst)
		(setup_phase && !pwrite && hit_step) |=> (prdata[7:0] == step_view($past(step_oh)) && !prdata[`TSS_STEP_MSB_BIT] && prdata[31:8] == 24'h000000)) else $error("step read wrong");

	write_ignored_a: assert property (@(posedge ref_clk) disable iff (rst)
		(psel && penable && pready && pwrite && hit_step) |=> (local_en == $past(local_en))) else $error("step write had an effect");

	apb_answer_a: assert property (@(posedge ref_clk) disable iff (rst)
		setup_phase |=> pready ##1 !pready) else $error("answer timing wrong");

	local_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
		(local_en && gen_rise) |=> (sclk_out && step == $past(next_step))) else $error("local edge misaligned");

	echo_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
		(!local_en && echo_blank != 2'h0) |=> $stable(step)) else $error("own edge counted twice");

	reset_zero_a: assert property (@(posedge ref_clk)
		$fell(rst) |-> (step == `TSS_FIRST_STEP || step == 6'h01)) else $error("reset did not clear step");

endmodule // tss_top
